/* File: hw/tsp_master.sv */
// Host end: issues register writes and write-then-restart reads.
// Assumes one request at a time, held until done pulses.
`timescale 1ns/1ps
`include "tsp_consts.svh"
module tsp_master (
   input wire logic sys_clk, // System clock
   input wire logic rst_n, // Async reset
   tsp_bus_if.master bus, // Serial bus
   input wire logic req, // Start a transfer
   input wire logic rnw, // 1 read, 0 write
   input wire logic [6:0] dev_addr, // Target address
   input wire logic [7:0] reg_addr, // Register address
   input wire logic [7:0] wr_data, // Write data
   output logic done, // Transfer finished pulse
   output logic nack, // Any sent byte not acknowledged
   output logic [7:0] rd_data // Read data
);
   import tsp_pkg::*;
   localparam int QTR = `TSP_QTR_CYC;
   tsp_mstate_t st_q, st_d;
   logic [15:0] tm_q, tm_d;
   logic [1:0] ph_q, ph_d;
   logic [3:0] bit_q, bit_d;
   logic [1:0] byte_q, byte_d;
   logic [7:0] sh_q, sh_d, rd_data_d;
   logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d, rs_q, rs_d, done_d, nack_d;
   logic [1:0] sda_s_q, sda_s_d;
   logic tick;
   assign tick = (tm_q == 16'(QTR - 1));
   ////////////////////////////////////////////////////////////
   always_comb begin
      // Data pin may come from another chip; two flops before use
      sda_s_d = {sda_s_q[0], bus.sda};
      st_d = st_q;
      tm_d = tick ? 16'h0000 : tm_q + 16'h0001;
      ph_d = ph_q;
      bit_d = bit_q;
      byte_d = byte_q;
      sh_d = sh_q;
      rd_data_d = rd_data;
      scl_oe_d = scl_oe_q;
      sda_oe_d = sda_oe_q;
      rs_d = rs_q;
      done_d = 1'b0;
      nack_d = nack;
      if (st_q == TSP_M_IDLE) begin
         tm_d = 16'h0000;
         sda_oe_d = 1'b0;
         scl_oe_d = 1'b0;
         // Request still high while done pulses must not restart
         if (req && !done) begin
            st_d = TSP_M_START;
            ph_d = 2'h0;
            rs_d = 1'b0;
            nack_d = 1'b0;
         end
      end else if (tick) begin
         ph_d = ph_q + 2'h1;
         case (st_q)
            TSP_M_START: begin
               case (ph_q)
                  2'h0: sda_oe_d = 1'b0;
                  2'h1: scl_oe_d = 1'b0;
                  2'h2: sda_oe_d = 1'b1;
                  default: begin
                     scl_oe_d = 1'b1;
                     byte_d = rs_q ? 2'h3 : 2'h0;
                     sh_d = {dev_addr, rs_q ? `TSP_DIR_READ : `TSP_DIR_WRITE};
                     bit_d = 4'h0;
                     st_d = TSP_M_BIT;
                  end
               endcase
            end
            TSP_M_BIT, TSP_M_ACK, TSP_M_RBIT, TSP_M_NACK: begin
               case (ph_q)
                  2'h0: begin
                     if (st_q == TSP_M_BIT) sda_oe_d = ~sh_q[7];
                     else sda_oe_d = 1'b0;
                  end
                  2'h1: scl_oe_d = 1'b0;
                  2'h2: scl_oe_d = 1'b0;
                  default: begin
                     scl_oe_d = 1'b1;
                     if (st_q == TSP_M_BIT) begin
                        sh_d = {sh_q[6:0], 1'b0};
                        bit_d = bit_q + 4'h1;
                        if (bit_q == 4'h7) st_d = TSP_M_ACK;
                     end else if (st_q == TSP_M_RBIT) begin
                        sh_d = {sh_q[6:0], sda_s_q[1]};
                        bit_d = bit_q + 4'h1;
                        if (bit_q == 4'h7) st_d = TSP_M_NACK;
                     end else if (st_q == TSP_M_NACK) begin
                        rd_data_d = sh_q;
                        st_d = TSP_M_STOP;
                     end else if (sda_s_q[1]) begin
                        nack_d = 1'b1;
                        st_d = TSP_M_STOP;
                     end else begin
                        bit_d = 4'h0;
                        byte_d = byte_q + 2'h1;
                        case (byte_q)
                           2'h0: begin
                              sh_d = reg_addr;
                              st_d = TSP_M_BIT;
                           end
                           2'h1: begin
                              if (rnw) begin
                                 rs_d = 1'b1;
                                 st_d = TSP_M_START;
                              end else begin
                                 sh_d = wr_data;
                                 st_d = TSP_M_BIT;
                              end
                           end
                           2'h2: st_d = TSP_M_STOP;
                           default: st_d = TSP_M_RBIT;
                        endcase
                     end
                  end
               endcase
            end
            TSP_M_STOP: begin
               case (ph_q)
                  2'h0: sda_oe_d = 1'b1;
                  2'h1: scl_oe_d = 1'b0;
                  2'h2: sda_oe_d = 1'b0;
                  default: st_d = TSP_M_DONE;
               endcase
            end
            default: begin
               done_d = 1'b1;
               st_d = TSP_M_IDLE;
            end
         endcase
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_s_q <= 2'h3;
         st_q <= TSP_M_IDLE;
         tm_q <= 16'h0000;
         ph_q <= 2'h0;
         bit_q <= 4'h0;
         byte_q <= 2'h0;
         sh_q <= 8'h00;
         rd_data <= 8'h00;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         rs_q <= 1'b0;
         done <= 1'b0;
         nack <= 1'b0;
      end else begin
         sda_s_q <= sda_s_d;
         st_q <= st_d;
         tm_q <= tm_d;
         ph_q <= ph_d;
         bit_q <= bit_d;
         byte_q <= byte_d;
         sh_q <= sh_d;
         rd_data <= rd_data_d;
         scl_oe_q <= scl_oe_d;
         sda_oe_q <= sda_oe_d;
         rs_q <= rs_d;
         done <= done_d;
         nack <= nack_d;
      end
   end
   assign bus.scl_oe = scl_oe_q;
   assign bus.sda_m_oe = sda_oe_q;
endmodule

/* File: hw/tsp_consts.svh */
// Constants of the two-wire touch sensor target port and its bus master.
// Assumes inclusion by both ends; holds definitions only.
// Function
// - First byte: seven address bits, then direction
// - Respond only when address top bits are 10001
// - Strap: GND 00, VCC 11, SCL 01, SDA 10
// - Sample data while clock stably high
// - Master keeps data high when idle
// - START: data falls while clock high
// - Compare address after every START
// - Master sends address MSB first, stable
// - Matching address: hold data low during ack
// - No ack: master sends STOP, abandons
// - Register-address byte sent and acknowledged
// - Write data byte sent and acknowledged
// - STOP: data rises while clock high, idle
// - Read: address with direction 0, command
// - After repeated START, address with direction 1
// - Device shifts out selected register contents
`ifndef TSP_CONSTS_SVH
`define TSP_CONSTS_SVH
`define TSP_ADDR_FIXED 5'h11
`define TSP_STRAP_GND 2'h0
`define TSP_STRAP_VCC 2'h3
`define TSP_STRAP_SCL 2'h1
`define TSP_STRAP_SDA 2'h2
`define TSP_DIR_WRITE 1'h0
`define TSP_DIR_READ 1'h1
`define TSP_CLK_MHZ 100
`define TSP_QTR_NS 625
`define TSP_QTR_CYC ((`TSP_QTR_NS * `TSP_CLK_MHZ + 999) / 1000)
`endif

/* File: hw/tsp_pkg.sv */
// Types shared by both ends of the touch sensor target port.
// Assumes the constants header is included by users needing numbers.
package tsp_pkg;
   typedef enum logic [1:0] {
      TSP_STRAP_IS_GND,
      TSP_STRAP_IS_VCC,
      TSP_STRAP_IS_SCL,
      TSP_STRAP_IS_SDA
   } tsp_strap_t;
   typedef enum logic [2:0] {
      TSP_T_IDLE,
      TSP_T_ADDR,
      TSP_T_ACK,
      TSP_T_RX,
      TSP_T_TX,
      TSP_T_TXACK,
      TSP_T_IGNORE
   } tsp_tstate_t;
   typedef enum logic [3:0] {
      TSP_M_IDLE,
      TSP_M_START,
      TSP_M_BIT,
      TSP_M_ACK,
      TSP_M_RBIT,
      TSP_M_NACK,
      TSP_M_STOP,
      TSP_M_DONE
   } tsp_mstate_t;
endpackage

/* File: hw/tsp_bus_if.sv */
// Two-wire bus between host master and touch sensor target.
// Assumes open-drain wiring with pull-ups; resolved here.
`timescale 1ns/1ps
interface tsp_bus_if;
   logic scl_oe;
   logic sda_m_oe;
   logic sda_t_oe;
   logic scl;
   logic sda;
   assign scl = ~scl_oe;
   assign sda = ~(sda_m_oe | sda_t_oe);
   modport master (output scl_oe, output sda_m_oe, input scl, input sda);
   modport target (output sda_t_oe, input scl, input sda);
endinterface

/* File: hw/tsp_target.sv */
// Target end: address match, acknowledges, register byte shifting.
// Assumes register file outside; strap level sampled by caller's choice.
`timescale 1ns/1ps
`include "tsp_consts.svh"
module tsp_target (
   input wire logic sys_clk, // System clock
   input wire logic rst_n, // Async reset
   tsp_bus_if.target bus, // Serial bus
   input wire tsp_pkg::tsp_strap_t strap, // Address-select connection
   input wire logic [7:0] rd_data, // Selected register contents
   output logic [7:0] reg_addr, // Register address
   output logic [7:0] wr_data, // Written data
   output logic wr_stb, // Write pulse
   output logic busy // Addressed in a transfer
);
   import tsp_pkg::*;
   logic [1:0] scl_s_q, sda_s_q, scl_s_d, sda_s_d;
   logic scl_q, sda_q, scl_d, sda_d;
   tsp_tstate_t st_q, st_d;
   logic [7:0] sh_q, sh_d, reg_addr_d, wr_data_d;
   logic [3:0] cnt_q, cnt_d;
   logic rd_q, rd_d, first_q, first_d, oe_q, oe_d, wr_stb_d;
   logic [1:0] strap_bits;
   logic start, stop, rise, fall;
   always_comb begin
      case (strap)
         TSP_STRAP_IS_GND: strap_bits = `TSP_STRAP_GND;
         TSP_STRAP_IS_VCC: strap_bits = `TSP_STRAP_VCC;
         TSP_STRAP_IS_SCL: strap_bits = `TSP_STRAP_SCL;
         default: strap_bits = `TSP_STRAP_SDA;
      endcase
   end
   assign start = scl_q & scl_s_q[1] & sda_q & ~sda_s_q[1];
   assign stop = scl_q & scl_s_q[1] & ~sda_q & sda_s_q[1];
   assign rise = ~scl_q & scl_s_q[1];
   assign fall = scl_q & ~scl_s_q[1];
   ////////////////////////////////////////////////////////////
   always_comb begin
      scl_s_d = {scl_s_q[0], bus.scl};
      sda_s_d = {sda_s_q[0], bus.sda};
      scl_d = scl_s_q[1];
      sda_d = sda_s_q[1];
      st_d = st_q;
      sh_d = sh_q;
      cnt_d = cnt_q;
      rd_d = rd_q;
      first_d = first_q;
      oe_d = oe_q;
      reg_addr_d = reg_addr;
      wr_data_d = wr_data;
      wr_stb_d = 1'b0;
      if (start) begin
         st_d = TSP_T_ADDR;
         cnt_d = 4'h0;
         oe_d = 1'b0;
      end else if (stop) begin
         st_d = TSP_T_IDLE;
         oe_d = 1'b0;
      end else begin
         case (st_q)
            TSP_T_ADDR, TSP_T_RX: begin
               if (rise) begin
                  sh_d = {sh_q[6:0], sda_s_q[1]};
                  cnt_d = cnt_q + 4'h1;
               end
               if (fall && cnt_q == 4'h8) begin
                  cnt_d = 4'h0;
                  if (st_q == TSP_T_ADDR) begin
                     if (sh_q[7:1] == {`TSP_ADDR_FIXED, strap_bits}) begin
                        rd_d = sh_q[0];
                        first_d = 1'b1;
                        oe_d = 1'b1;
                        st_d = TSP_T_ACK;
                     end else begin
                        st_d = TSP_T_IGNORE;
                     end
                  end else begin
                     if (first_q) begin
                        reg_addr_d = sh_q;
                     end else begin
                        wr_data_d = sh_q;
                        wr_stb_d = 1'b1;
                     end
                     first_d = 1'b0;
                     oe_d = 1'b1;
                     st_d = TSP_T_ACK;
                  end
               end
            end
            TSP_T_ACK: begin
               if (fall) begin
                  if (rd_q == `TSP_DIR_READ) begin
                     sh_d = {rd_data[6:0], 1'b0};
                     oe_d = ~rd_data[7];
                     cnt_d = 4'h1;
                     st_d = TSP_T_TX;
                  end else begin
                     oe_d = 1'b0;
                     st_d = TSP_T_RX;
                  end
               end
            end
            TSP_T_TX: begin
               if (fall) begin
                  if (cnt_q == 4'h8) begin
                     oe_d = 1'b0;
                     st_d = TSP_T_TXACK;
                  end else begin
                     oe_d = ~sh_q[7];
                     sh_d = {sh_q[6:0], 1'b0};
                     cnt_d = cnt_q + 4'h1;
                  end
               end
            end
            TSP_T_TXACK: begin
               if (rise && sda_s_q[1]) begin
                  st_d = TSP_T_IGNORE;
               end else if (fall) begin
                  sh_d = rd_data;
                  cnt_d = 4'h0;
                  st_d = TSP_T_ACK;
               end
            end
            TSP_T_IDLE, TSP_T_IGNORE: oe_d = 1'b0;
            default: st_d = TSP_T_IDLE;
         endcase
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         st_q <= TSP_T_IDLE;
         sh_q <= 8'h00;
         cnt_q <= 4'h0;
         rd_q <= 1'b0;
         first_q <= 1'b0;
         oe_q <= 1'b0;
         reg_addr <= 8'h00;
         wr_data <= 8'h00;
         wr_stb <= 1'b0;
      end else begin
         scl_s_q <= scl_s_d;
         sda_s_q <= sda_s_d;
         scl_q <= scl_d;
         sda_q <= sda_d;
         st_q <= st_d;
         sh_q <= sh_d;
         cnt_q <= cnt_d;
         rd_q <= rd_d;
         first_q <= first_d;
         oe_q <= oe_d;
         reg_addr <= reg_addr_d;
         wr_data <= wr_data_d;
         wr_stb <= wr_stb_d;
      end
   end
   assign bus.sda_t_oe = oe_q;
   assign busy = (st_q != TSP_T_IDLE) && (st_q != TSP_T_IGNORE) && (st_q != TSP_T_ADDR);
endmodule

/* File: verification/tsp_asserts.sv */
// Checker of the two-wire bus between host master and touch sensor target.
// Assumes the bus interface signals as plain inputs, one clock domain.
`timescale 1ns/1ps
module tsp_asserts (
   input wire logic sys_clk, // System clock
   input wire logic rst_n, // Async reset
   input wire logic scl_oe, // Master pulls clock
   input wire logic sda_m_oe, // Master pulls data
   input wire logic sda_t_oe, // Target pulls data
   input wire logic scl, // Resolved clock
   input wire logic sda // Resolved data
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////////
   AST_T_STABLE_HI: assert property (scl && $past(scl) |-> $stable(sda_t_oe))
      else $error("target data enable moved while clock high");
   AST_T_CHANGE_LATE: assert property ($changed(sda_t_oe) |-> !scl && !$past(scl, 2))
      else $error("target data enable moved too close to a clock fall");
   AST_NO_FIGHT: assert property (sda_t_oe && scl |-> !sda_m_oe)
      else $error("master pulls data while target answers");
   AST_START_HOLD: assert property ($rose(sda_m_oe) && scl |-> scl [*8])
      else $error("clock not held high after start");
   AST_STOP_IDLE: assert property ($fell(sda_m_oe) && scl |=> (scl && !sda_t_oe) [*8])
      else $error("bus not idle after stop");
   AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl [*8])
      else $error("clock high period too short");
   AST_SCL_LOW_MIN: assert property ($fell(scl) |-> !scl [*8])
      else $error("clock low period too short");
   AST_IDLE_HIGH: assert property (scl && $rose(sda) |=> sda [*8])
      else $error("data line pulled low too soon after stop");
endmodule

/* File: verification/tsp_tb.sv */
// Self-checking bench joining host master and touch sensor target.
// Assumes both ends on one bus interface; the bench holds the register file.
`timescale 1ns/1ps
module testbench;
   import tsp_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic req = 1'b0;
   logic rnw = 1'b0;
   logic [6:0] dev_addr = 7'h00;
   logic [7:0] m_reg = 8'h00;
   logic [7:0] m_wdata = 8'h00;
   logic [7:0] t_rdata = 8'h00;
   tsp_strap_t strap = TSP_STRAP_IS_GND;
   logic done, nack, wr_stb, busy;
   logic [7:0] m_rdata, t_reg, t_wdata;
   logic [7:0] mem [256];
   int n_fail = 0;
   int total_checks = 0;
   int n_wr = 0;
   always #5 sys_clk = ~sys_clk;
   tsp_bus_if bus ();
   tsp_master tsp_master_inst (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus.master), .req(req), .rnw(rnw),
      .dev_addr(dev_addr), .reg_addr(m_reg), .wr_data(m_wdata), .done(done), .nack(nack), .rd_data(m_rdata));
   tsp_target tsp_target_inst (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus.target), .strap(strap),
      .rd_data(t_rdata), .reg_addr(t_reg), .wr_data(t_wdata), .wr_stb(wr_stb), .busy(busy));
   tsp_asserts tsp_asserts_inst (.sys_clk(sys_clk), .rst_n(rst_n), .scl_oe(bus.scl_oe),
      .sda_m_oe(bus.sda_m_oe), .sda_t_oe(bus.sda_t_oe), .scl(bus.scl), .sda(bus.sda));
   ////////////////////////////////////////////////////////////////////////////////
   // Register file lives here, outside the target
   initial foreach (mem[i]) mem[i] = 8'h00;
   always @(posedge sys_clk) begin
      t_rdata <= mem[t_reg];
      if (wr_stb === 1'b1) begin
         mem[t_reg] <= t_wdata;
         n_wr++;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // One host request, held until the done pulse; bounded wait
   task automatic xfer(input logic r, input logic [6:0] a, input logic [7:0] ra, input logic [7:0] wd);
      int i;
      @(posedge sys_clk);
      req <= 1'b1;
      rnw <= r;
      dev_addr <= a;
      m_reg <= ra;
      m_wdata <= wd;
      for (i = 0; i < 20000; i++) begin
         @(posedge sys_clk);
         if (done === 1'b1) begin
            break;
         end
      end
      req <= 1'b0;
      if (i == 20000) begin
         n_fail++;
         tally_and_finish();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Foreign addresses are refused and change nothing in the register file
   task automatic bad_address();
      logic [6:0] bad [3];
      int w;
      bad = '{7'h46, 7'h05, 7'h65};
      strap <= TSP_STRAP_IS_SCL;
      foreach (bad[k]) begin
         w = n_wr;
         xfer(1'b0, bad[k], 8'h07, 8'hEE);
         check({7'h00, nack}, 8'h01);
         check(8'(n_wr - w), 8'h00);
         check({7'h00, busy}, 8'h00);
      end
   endtask
   // Every strap: write then restart-read of the same register
   task automatic write_read(input int s);
      logic [1:0] bits [4];
      logic [7:0] dat [4];
      logic [6:0] a;
      logic [7:0] ra;
      int w;
      bits = '{2'h0, 2'h3, 2'h1, 2'h2};
      dat = '{8'h00, 8'hFF, 8'h5A, 8'h81};
      strap <= tsp_strap_t'(s[1:0]);
      a = {5'h11, bits[s]};
      ra = 8'h80 + 8'(s);
      w = n_wr;
      xfer(1'b0, a, ra, dat[s]);
      check({7'h00, nack}, 8'h00);
      check(8'(n_wr - w), 8'h01);
      check(t_reg, ra);
      check(mem[ra], dat[s]);
      check({6'h00, bus.scl, bus.sda}, 8'h03);
      xfer(1'b1, a, ra, 8'h00);
      check({7'h00, nack}, 8'h00);
      check(m_rdata, dat[s]);
      check(8'(n_wr - w), 8'h01);
      check({7'h00, bus.sda_t_oe}, 8'h00);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      bad_address();
      for (int s = 0; s < 4; s++) begin
         write_read(s);
      end
      tally_and_finish();
   end
endmodule
